/* File: cvr_pkg.sv */
// Shared constants and carriers for the conversion result register block.
package cvr_pkg;

  // Register offsets on the serial register port.
  localparam logic [7:0] ADDR_ITEMP_SUPPLY_LOW = 8'h03;
  localparam logic [7:0] ADDR_EXT_INPUTS_LOW   = 8'h04;
  localparam logic [7:0] ADDR_SUPPLY_HIGH      = 8'h06;
  localparam logic [7:0] ADDR_ITEMP_HIGH       = 8'h07;
  localparam logic [7:0] ADDR_EXT_OR_IN1_HIGH  = 8'h08;
  localparam logic [7:0] ADDR_IN2_HIGH         = 8'h09;
  localparam logic [7:0] ADDR_IN3_HIGH         = 8'h0a;
  localparam logic [7:0] ADDR_IN4_HIGH         = 8'h0b;
  localparam logic [7:0] ADDR_DAC_A_LOW        = 8'h10;

  // Data and result widths.
  localparam int RESULT_W = 10;
  localparam int REG_W    = 8;
  localparam int NUM_CH   = 7;

  // Channel slots inside the result store.
  localparam int CH_ITEMP  = 0;
  localparam int CH_SUPPLY = 1;
  localparam int CH_EXT    = 2;
  localparam int CH_IN1    = 3;
  localparam int CH_IN2    = 4;
  localparam int CH_IN3    = 5;
  localparam int CH_IN4    = 6;

  // Field positions: the high register holds result bits 9..2, the low pair bits 1..0.
  localparam int HIGH_MSB = 9;
  localparam int HIGH_LSB = 2;
  localparam int LOW_MSB  = 1;
  localparam int LOW_LSB  = 0;

  // Reset values.
  localparam logic [REG_W-1:0]    REG_ZERO          = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_ZERO       = 10'h000;
  localparam logic [RESULT_W-1:0] SUPPLY_RESET_VAL  = 10'h000;
  localparam logic [3:0]          UNUSED_NIBBLE     = 4'h0;

  // Source selection codes for the shared external temperature / first input slot.
  localparam logic [1:0] SRC_ANALOG_INPUT_ONE = 2'h0;

  // Writable masks of the first DAC channel low register per variant.
  localparam int          DAC_RES_12        = 12;
  localparam int          DAC_RES_10        = 10;
  localparam logic [7:0]  DAC_LOW_MASK_12   = 8'hf0;
  localparam logic [7:0]  DAC_LOW_MASK_10   = 8'hc0;

  // Register access request from the serial front end.
  typedef struct packed {
    logic             wrEn;
    logic             rdEn;
    logic [7:0]       addr;
    logic [REG_W-1:0] wrData;
  } cvr_req_t;

  // One conversion result handed over by a converter.
  typedef struct packed {
    logic                valid;
    logic [RESULT_W-1:0] data;
  } cvr_conv_t;

  // Read answer back to the serial front end.
  typedef struct packed {
    logic             valid;
    logic [REG_W-1:0] data;
  } cvr_rsp_t;

endpackage

/* File: cvr_result_slot.sv */
`timescale 1ns/100ps
// One stored conversion result, loaded by its converter strobe.
module cvr_result_slot
  import cvr_pkg::*;
#(
  parameter logic [RESULT_W-1:0] RESET_VAL = RESULT_ZERO
) (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                srst,
  // Converter side.
  input  wire logic                loadEn,
  input  wire logic [RESULT_W-1:0] loadData,
  // Stored value.
  output logic      [RESULT_W-1:0] result_r
);

  // The converter is the only writer, so host writes can never reach this flop.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      result_r <= RESET_VAL;
    end else if (loadEn) begin
      result_r <= loadData;
    end
  end

endmodule

/* File: cvr_result_regs.sv */
`timescale 1ns/100ps
// How it works
// - Register 0x03 holds temperature and supply low bits.
// - D1:D0 temperature low, D3:D2 supply low.
// - Register 0x04 holds low bits of other inputs.
// - Source select picks external temperature or input one.
// - Inputs two, three, four at D3:D2, D5:D4, D7:D6.
// - Supply high register holds bits 9..2, loaded.
// - Temperature high register holds signed bits 9..2.
// - Register 0x08 holds selected source high bits.
// - External temperature passes through unchanged, two's complement.
// - Input two high bits pair with D3:D2.
// - Input three high bits pair with D5:D4.
// - Input four high bits pair with D7:D6.
// - DAC channel one low register keeps upper bits.
// - DAC code starts at zero until written.
// - Result registers read zero after reset.
module cvr_result_regs
  import cvr_pkg::*;
#(
  parameter int DAC_RESOLUTION = DAC_RES_12
) (
  // Clock and reset.
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  // Register access from the serial front end.
  input  wire cvr_req_t               regReq,
  output cvr_rsp_t                    regRsp_r,
  // Converter results, one per channel slot.
  input  wire cvr_conv_t [NUM_CH-1:0] convIn,
  // Source selection field of the first configuration register.
  input  wire logic [1:0]             input_source_select,
  // Low bits of the first voltage output code.
  output logic [REG_W-1:0]            firstVoltageOutputLow_r
);

  // Stored results of every channel.
  logic [RESULT_W-1:0] result [NUM_CH];

  // One slot per channel; only the supply slot starts from its own value.
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_slot
      cvr_result_slot #(
        .RESET_VAL (ch == CH_SUPPLY ? SUPPLY_RESET_VAL : RESULT_ZERO)
      ) u_slot (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .loadEn   (convIn[ch].valid),
        .loadData (convIn[ch].data),
        .result_r (result[ch])
      );
    end
  endgenerate

  // The shared slot follows the source select; both results keep being stored so a
  // change of selection shows the latest value of the newly chosen source at once.
  wire logic                useInputOne = (input_source_select == SRC_ANALOG_INPUT_ONE);
  wire logic [RESULT_W-1:0] sharedRes   = useInputOne ? result[CH_IN1] : result[CH_EXT];

  // Assembled register images.
  wire logic [REG_W-1:0] itempSupplyLow = {UNUSED_NIBBLE,
                                           result[CH_SUPPLY][LOW_MSB:LOW_LSB],
                                           result[CH_ITEMP][LOW_MSB:LOW_LSB]};
  wire logic [REG_W-1:0] extInputsLow   = {result[CH_IN4][LOW_MSB:LOW_LSB],
                                           result[CH_IN3][LOW_MSB:LOW_LSB],
                                           result[CH_IN2][LOW_MSB:LOW_LSB],
                                           sharedRes[LOW_MSB:LOW_LSB]};
  wire logic [REG_W-1:0] supplyHigh     = result[CH_SUPPLY][HIGH_MSB:HIGH_LSB];
  wire logic [REG_W-1:0] itempHigh      = result[CH_ITEMP][HIGH_MSB:HIGH_LSB];
  wire logic [REG_W-1:0] sharedHigh     = sharedRes[HIGH_MSB:HIGH_LSB];
  wire logic [REG_W-1:0] in2High        = result[CH_IN2][HIGH_MSB:HIGH_LSB];
  wire logic [REG_W-1:0] in3High        = result[CH_IN3][HIGH_MSB:HIGH_LSB];
  wire logic [REG_W-1:0] in4High        = result[CH_IN4][HIGH_MSB:HIGH_LSB];

  // Address decode.
  wire logic hitItempSupplyLow = (regReq.addr == ADDR_ITEMP_SUPPLY_LOW);
  wire logic hitExtInputsLow   = (regReq.addr == ADDR_EXT_INPUTS_LOW);
  wire logic hitSupplyHigh     = (regReq.addr == ADDR_SUPPLY_HIGH);
  wire logic hitItempHigh      = (regReq.addr == ADDR_ITEMP_HIGH);
  wire logic hitSharedHigh     = (regReq.addr == ADDR_EXT_OR_IN1_HIGH);
  wire logic hitIn2High        = (regReq.addr == ADDR_IN2_HIGH);
  wire logic hitIn3High        = (regReq.addr == ADDR_IN3_HIGH);
  wire logic hitIn4High        = (regReq.addr == ADDR_IN4_HIGH);
  wire logic hitDacLow         = (regReq.addr == ADDR_DAC_A_LOW);

  // Only the DAC low register accepts writes, and only in its implemented upper bits.
  wire logic [REG_W-1:0] dacLowMask = (DAC_RESOLUTION == DAC_RES_10) ? DAC_LOW_MASK_10 : DAC_LOW_MASK_12;
  wire logic             dacLowWr   = regReq.wrEn & hitDacLow;
  wire logic [REG_W-1:0] dacLow_nxt = regReq.wrData & dacLowMask;

  // Read selection; unmapped offsets read as zero.
  wire logic [REG_W-1:0] rdSel =
      hitItempSupplyLow ? itempSupplyLow :
      hitExtInputsLow   ? extInputsLow   :
      hitSupplyHigh     ? supplyHigh     :
      hitItempHigh      ? itempHigh      :
      hitSharedHigh     ? sharedHigh     :
      hitIn2High        ? in2High        :
      hitIn3High        ? in3High        :
      hitIn4High        ? in4High        :
      hitDacLow         ? firstVoltageOutputLow_r :
                          REG_ZERO;

  // The DAC code stays at zero from reset until the host writes it.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      firstVoltageOutputLow_r <= REG_ZERO;
    end else if (dacLowWr) begin
      firstVoltageOutputLow_r <= dacLow_nxt;
    end
  end

  // Read answer is registered, one cycle after the request, so the output is a flop.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      regRsp_r <= '0;
    end else begin
      regRsp_r.valid <= regReq.rdEn;
      regRsp_r.data  <= regReq.rdEn ? rdSel : REG_ZERO;
    end
  end

  // Checks on the register behaviour. Every result read check compares the registered answer
  // with the stored results one cycle earlier, which is when the request was taken.
  // Looking at the answer in the request cycle would see the previous answer instead,
  // so all read checks use a one-cycle implication, and the result checks sample the store with $past.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // An offset that lands on no mapped register; such reads must answer zero.
  wire logic hitNone = ~(hitItempSupplyLow | hitExtInputsLow | hitSupplyHigh | hitItempHigh |
                         hitSharedHigh | hitIn2High | hitIn3High | hitIn4High | hitDacLow);

  // The answer comes exactly one cycle after the read strobe.
  // The serial front end counts on this fixed latency and has no wait state,
  // so a late answer would be lost rather than merely slow.
  rsp_timing_a: assert property (regReq.rdEn |=> regRsp_r.valid)
    else $error("Read answer did not follow the request.");

  // Without a read strobe the answer stays quiet and its data stays zero.
  // A stale byte left on the data lines could be shifted out by a sloppy front end,
  // so the data is forced to zero whenever valid is low.
  rsp_idle_a: assert property (!regReq.rdEn |=> !regRsp_r.valid && regRsp_r.data == REG_ZERO)
    else $error("Read answer appeared without a request.");

  // The first low-bits register: temperature pair in D1:D0, supply pair in D3:D2.
  // Checked as a whole byte so that a swap of the two pairs is caught as well.
  // The upper nibble is unused and must read zero.
  low_a_image_a: assert property (regReq.rdEn && hitItempSupplyLow |=>
      regRsp_r.data == {UNUSED_NIBBLE, $past(result[CH_SUPPLY][LOW_MSB:LOW_LSB]),
                        $past(result[CH_ITEMP][LOW_MSB:LOW_LSB])})
    else $error("Temperature and supply low bits misplaced.");

  // The unused upper nibble of the first low-bits register is checked on its own.
  // It has no storage behind it, so any one there would point at a wiring slip.
  // This guard stays valid even if the pair layout is changed later.
  low_a_unused_a: assert property (regReq.rdEn && hitItempSupplyLow |=>
      regRsp_r.data[REG_W-1:REG_W-4] == UNUSED_NIBBLE)
    else $error("Unused nibble of the first low-bits register not zero.");

  // The second low-bits register: inputs two, three and four in ascending pairs.
  // The lower bit of each pair is the least significant result bit.
  // A reversed pair would still look plausible, so the order is checked exactly.
  low_b_image_a: assert property (regReq.rdEn && hitExtInputsLow |=>
      regRsp_r.data[REG_W-1:HIGH_LSB] == {$past(result[CH_IN4][LOW_MSB:LOW_LSB]),
                                          $past(result[CH_IN3][LOW_MSB:LOW_LSB]),
                                          $past(result[CH_IN2][LOW_MSB:LOW_LSB])})
    else $error("Input low bit pairs misplaced.");

  // The lowest pair of the second low-bits register follows the source select.
  // The select is sampled with the request, because it may change the next cycle.
  // Both stored results are compared so a wrong choice is caught either way.
  shared_low_a: assert property (regReq.rdEn && hitExtInputsLow |=>
      regRsp_r.data[LOW_MSB:LOW_LSB] == ($past(useInputOne) ? $past(result[CH_IN1][LOW_MSB:LOW_LSB])
                                                            : $past(result[CH_EXT][LOW_MSB:LOW_LSB])))
    else $error("Shared low pair ignored the source select.");

  // The shared high register shows input one when that source is chosen.
  // The selection is live on read, so the select of the request cycle decides.
  // A latched select would show the previous source here and trip this check.
  shared_sel_a: assert property (regReq.rdEn && hitSharedHigh && useInputOne |=>
      regRsp_r.data == $past(result[CH_IN1][HIGH_MSB:HIGH_LSB]))
    else $error("Shared slot ignored the source select.");

  // With any other select code the external temperature shows, unchanged.
  // Its two's complement form passes straight through; no sign handling is done,
  // so a negative temperature keeps its sign bit in D7.
  ext_temp_a: assert property (regReq.rdEn && hitSharedHigh && !useInputOne |=>
      regRsp_r.data == $past(result[CH_EXT][HIGH_MSB:HIGH_LSB]))
    else $error("External temperature high bits wrong.");

  // The supply high register holds result bits 9 down to 2.
  // Until the first supply conversion it shows the supply reset value.
  // The check covers both, as it compares against whatever the slot holds.
  supply_high_a: assert property (regReq.rdEn && hitSupplyHigh |=>
      regRsp_r.data == $past(result[CH_SUPPLY][HIGH_MSB:HIGH_LSB]))
    else $error("Supply high bits wrong.");

  // The temperature high register holds the signed bits 9 down to 2.
  // The sign bit lands in D7, so the byte reads as a signed value by itself.
  itemp_high_a: assert property (regReq.rdEn && hitItempHigh |=>
      regRsp_r.data == $past(result[CH_ITEMP][HIGH_MSB:HIGH_LSB]))
    else $error("Temperature high bits wrong.");

  // Input two high bits; together with D3:D2 of the second low-bits register
  // they give the full ten-bit result.
  in2_high_a: assert property (regReq.rdEn && hitIn2High |=>
      regRsp_r.data == $past(result[CH_IN2][HIGH_MSB:HIGH_LSB]))
    else $error("Input two high bits wrong.");

  // Input three high bits; together with D5:D4 of the second low-bits register
  // they give the full ten-bit result.
  in3_high_a: assert property (regReq.rdEn && hitIn3High |=>
      regRsp_r.data == $past(result[CH_IN3][HIGH_MSB:HIGH_LSB]))
    else $error("Input three high bits wrong.");

  // Input four high bits; together with D7:D6 of the second low-bits register
  // they give the full ten-bit result.
  in4_high_a: assert property (regReq.rdEn && hitIn4High |=>
      regRsp_r.data == $past(result[CH_IN4][HIGH_MSB:HIGH_LSB]))
    else $error("Input four high bits wrong.");

  // An offset with no register behind it answers zero but still answers.
  // Answering keeps the front end's fixed latency intact for every offset.
  unmapped_read_a: assert property (regReq.rdEn && hitNone |=>
      regRsp_r.valid && regRsp_r.data == REG_ZERO)
    else $error("Unmapped offset did not read as zero.");

  // A read of the DAC low register returns the code as it stood at the request.
  // When a write to the same offset falls in the same cycle, the read sees the old
  // code; the new one is only visible one cycle later.
  dac_read_a: assert property (regReq.rdEn && hitDacLow |=>
      regRsp_r.data == $past(firstVoltageOutputLow_r))
    else $error("DAC low register read back wrong.");

  // A supply strobe lands in its slot on the next cycle.
  // This is the path that replaces the supply reset value with a measured one.
  supply_load_a: assert property (convIn[CH_SUPPLY].valid |=>
      result[CH_SUPPLY] == $past(convIn[CH_SUPPLY].data))
    else $error("Supply result not loaded.");

  // Every slot loads on its own strobe and otherwise holds its value.
  // Host writes have no path into the slots, and these checks make sure
  // that no later change adds one by accident.
  for (ch = 0; ch < NUM_CH; ch++) begin : g_slot_chk
    slot_load_a: assert property (convIn[ch].valid |=>
        result[ch] == $past(convIn[ch].data))
      else $error("Result slot did not load on its strobe.");

    slot_hold_a: assert property (!convIn[ch].valid |=> $stable(result[ch]))
      else $error("Result slot changed without a strobe.");
  end

  // A write to any read-only offset leaves the DAC code untouched.
  // The decode of the write strobe is the only thing between a stray write
  // and the DAC output, so it is watched here directly.
  ro_write_a: assert property (regReq.wrEn && !hitDacLow |=>
      $stable(firstVoltageOutputLow_r))
    else $error("Write to a read-only offset disturbed the DAC code.");

  // Between writes the DAC code holds still.
  // A code that drifted between writes would move the output voltage unasked.
  dac_hold_a: assert property (!dacLowWr |=> $stable(firstVoltageOutputLow_r))
    else $error("DAC code changed without a write.");

  // A write keeps only the implemented upper bits of the DAC low register.
  // The lower bits have no storage, so they must read zero whatever was written.
  dac_mask_a: assert property (dacLowWr |=>
      firstVoltageOutputLow_r == ($past(regReq.wrData) & dacLowMask))
    else $error("DAC low register kept unimplemented bits.");

  // The unimplemented bits of the DAC low register stay zero at all times.
  // This holds beyond the write cycle, so a later path that sets them is caught too.
  dac_unimpl_a: assert property ((firstVoltageOutputLow_r & ~dacLowMask) == REG_ZERO)
    else $error("Unimplemented DAC bits set.");

  // Reset clears the DAC code and the answer port one cycle later.
  // This check must run while reset is active, so it switches off the default
  // disable condition and watches the reset itself.
  reset_dac_a: assert property (disable iff (1'b0)
      srst |=> firstVoltageOutputLow_r == REG_ZERO && !regRsp_r.valid && regRsp_r.data == REG_ZERO)
    else $error("Reset did not clear the DAC code or answer.");

  // Reset returns every result slot to zero, the supply slot to its own value.
  // A strobe in the reset cycle must lose against the reset.
  reset_results_a: assert property (disable iff (1'b0)
      srst |=> result[CH_ITEMP] == RESULT_ZERO && result[CH_EXT] == RESULT_ZERO &&
               result[CH_IN1] == RESULT_ZERO && result[CH_IN2] == RESULT_ZERO &&
               result[CH_IN3] == RESULT_ZERO && result[CH_IN4] == RESULT_ZERO)
    else $error("Reset did not clear the result slots.");

  // The supply slot comes out of reset with its own reset value.
  reset_supply_a: assert property (disable iff (1'b0)
      srst |=> result[CH_SUPPLY] == SUPPLY_RESET_VAL)
    else $error("Supply slot reset value wrong.");

endmodule

/* File: cvr_host_model.sv */
`timescale 1ns/100ps
// Host side of the register port: one strobe per access, answer taken one cycle later.
module cvr_host_model
  import cvr_pkg::*;
(
  // Clock.
  input  wire logic     sys_clk,
  // Register port.
  output cvr_req_t      regReq,
  input  wire cvr_rsp_t regRsp_r
);
  initial regReq = '0;

  // A write is a single-cycle strobe and gets no answer.
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge sys_clk);
    regReq <= '0;
  endtask

  // Data is taken after the accepting edge; a missing answer reads as unknown.
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(posedge sys_clk);
    regReq <= '0;
    #1;
    d = regRsp_r.valid ? regRsp_r.data : 8'hxx;
  endtask
endmodule

/* File: cvr_result_regs_tb_top.sv */
`timescale 1ns/100ps
// Self-checking bench for the result register block.
module cvr_result_regs_tb_top;
  import cvr_pkg::*;
  typedef struct { logic [7:0] addr; logic [1:0] sel; logic [7:0] exp; } cvr_row_t;
  logic                   sys_clk = 1'b0;
  logic                   srst    = 1'b1;
  cvr_req_t               regReq;
  cvr_rsp_t               regRsp_r;
  cvr_conv_t [NUM_CH-1:0] convIn  = '0;
  logic [1:0]             srcSel  = 2'h0;
  logic [7:0]             dacLow;
  logic [7:0]             dacLow10;
  logic [7:0]             rdData;
  logic [RESULT_W-1:0]    e;
  logic [RESULT_W-1:0]    v [NUM_CH] = '{10'h2c6, 10'h15b, 10'h3a1, 10'h0f2, 10'h1e7, 10'h26c, 10'h339};
  cvr_row_t               rows [$];
  int                     failCount = 0;
  int                     nTests    = 0;

  cvr_result_regs cvr_result_regs_inst (.sys_clk(sys_clk), .srst(srst), .regReq(regReq), .regRsp_r(regRsp_r),
    .convIn(convIn), .input_source_select(srcSel), .firstVoltageOutputLow_r(dacLow));
  // The 10-bit variant shares the request lines; only its DAC code is compared.
  cvr_result_regs #(.DAC_RESOLUTION(DAC_RES_10)) cvr_result_regs_10b_inst (.sys_clk(sys_clk), .srst(srst),
    .regReq(regReq), .regRsp_r(), .convIn(convIn), .input_source_select(srcSel),
    .firstVoltageOutputLow_r(dacLow10));
  cvr_host_model cvr_host_model_inst (.sys_clk(sys_clk), .regReq(regReq), .regRsp_r(regRsp_r));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdCheck(input logic [7:0] a, input logic [7:0] exp);
    cvr_host_model_inst.rdReg(a, rdData);
    checkByte($sformatf("read %h", a), exp, rdData);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Every mapped register must read zero after reset, the supply high byte included.
  task automatic zeroCheck;
    logic [7:0] addrs [9] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h10};
    foreach (addrs[i]) rdCheck(addrs[i], 8'h00);
    checkByte("dac low output", 8'h00, dacLow);
    checkByte("dac low output 10-bit", 8'h00, dacLow10);
  endtask

  // The whole run needs well under a thousand cycles; this bound only catches a hang.
  initial begin
    #20000;
    $display("watchdog expired");
    failCount++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    zeroCheck();
    $display("test reset values done");
    // All channels strobe on the same edge, which the converter port allows.
    @(posedge sys_clk);
    foreach (v[c]) convIn[c] <= '{valid: 1'b1, data: v[c]};
    @(posedge sys_clk);
    convIn <= '0;
    for (int s = 0; s < 4; s++) begin
      e = (s == 0) ? v[3] : v[2];
      rows.push_back('{8'h04, s[1:0], {v[6][1:0], v[5][1:0], v[4][1:0], e[1:0]}});
      rows.push_back('{8'h08, s[1:0], e[9:2]});
    end
    rows.push_back('{8'h03, 2'h0, {4'h0, v[1][1:0], v[0][1:0]}});
    rows.push_back('{8'h06, 2'h0, v[1][9:2]});
    rows.push_back('{8'h07, 2'h0, v[0][9:2]});
    rows.push_back('{8'h09, 2'h0, v[4][9:2]});
    rows.push_back('{8'h0a, 2'h0, v[5][9:2]});
    rows.push_back('{8'h0b, 2'h0, v[6][9:2]});
    rows.push_back('{8'h05, 2'h0, 8'h00});
    foreach (rows[i]) begin
      @(posedge sys_clk);
      srcSel <= rows[i].sel;
      rdCheck(rows[i].addr, rows[i].exp);
    end
    $display("test result table done");
    // Only the upper nibble of the low DAC byte is writable in the 12-bit variant.
    cvr_host_model_inst.wrReg(ADDR_DAC_A_LOW, 8'hff);
    @(posedge sys_clk);
    checkByte("dac low output", DAC_LOW_MASK_12, dacLow);
    checkByte("dac low output 10-bit", DAC_LOW_MASK_10, dacLow10);
    rdCheck(ADDR_DAC_A_LOW, DAC_LOW_MASK_12);
    for (int a = 3; a < 12; a++) cvr_host_model_inst.wrReg(a[7:0], 8'h5a);
    rdCheck(ADDR_ITEMP_HIGH, v[0][9:2]);
    rdCheck(ADDR_IN4_HIGH, v[6][9:2]);
    rdCheck(ADDR_DAC_A_LOW, DAC_LOW_MASK_12);
    $display("test writes done");
    // A second reset in mid-run must clear results and the DAC code again.
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    zeroCheck();
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
